// >>> lfc_pkg.sv
package lfc_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] LFC_ADDR_MODE = 8'h01;
    localparam logic [7:0] LFC_ADDR_CFG = 8'h02;
    localparam logic [7:0] LFC_ADDR_FLASH = 8'h03;
    localparam logic [7:0] LFC_ADDR_TORCH = 8'h04;
    localparam logic [7:0] LFC_ADDR_FLAGS = 8'h05;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] LFC_RST_MODE = 8'h00;
    localparam logic [7:0] LFC_RST_CFG = 8'h00;
    localparam logic [7:0] LFC_RST_FLASH = 8'h00;
    localparam logic [7:0] LFC_RST_TORCH = 8'h00;
    // ----------------------------------------
    // mode codes and field positions
    // ----------------------------------------
    localparam logic [1:0] LFC_MODE_STBY = 2'h0;
    localparam logic [1:0] LFC_MODE_IR = 2'h1;
    localparam logic [1:0] LFC_MODE_TORCH = 2'h2;
    localparam logic [1:0] LFC_MODE_FLASH = 2'h3;
    localparam int LFC_CFG_RAMP_BIT = 0;
    localparam int LFC_CFG_FTO_LSB = 1;
    localparam int LFC_CFG_DROOP_LSB = 5;
    localparam int LFC_FLAG_OVP = 0;
    localparam int LFC_FLAG_UVLO = 1;
    localparam int LFC_FLAG_TSB = 2;
    localparam int LFC_FLAG_TSD = 3;
    localparam int LFC_FLAG_OCP = 4;
    localparam int LFC_FLAG_SHORT = 5;
    localparam int LFC_FLAG_DROOP = 6;
    localparam int LFC_FLAG_FTO = 7;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int LFC_CLK_MHZ = 100;
    localparam int LFC_FTO_BASE_MS = 40;
    localparam int LFC_FTO_BASE_CYC = LFC_FTO_BASE_MS * LFC_CLK_MHZ * 1000;
    localparam int LFC_STEP_FAST_NS = 1000;
    localparam int LFC_STEP_SLOW_NS = 8000;
    localparam int LFC_STEP_FAST_CYC = LFC_STEP_FAST_NS * LFC_CLK_MHZ / 1000;
    localparam int LFC_STEP_SLOW_CYC = LFC_STEP_SLOW_NS * LFC_CLK_MHZ / 1000;
    localparam int LFC_OVP_TRIPS = 3;
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [3:0] {
        LFC_ST_IDLE = 4'b0001,
        LFC_ST_RAMP = 4'b0010,
        LFC_ST_HOLD = 4'b0100,
        LFC_ST_LOCK = 4'b1000
    } lfc_state_t;
endpackage

// >>> lfc_ramp_step.sv
`timescale 1ns/1ns
// ----------------------------------------
// ramp step pacer
// ----------------------------------------
module lfc_ramp_step import lfc_pkg::*; #(
    parameter int FAST_CYC = LFC_STEP_FAST_CYC,
    parameter int SLOW_CYC = LFC_STEP_SLOW_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic slow,
    output logic tick
);
    logic [15:0] cnt_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !run) begin
            cnt_r <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_r >= (slow ? 16'(SLOW_CYC - 1) : 16'(FAST_CYC - 1))) begin
            cnt_r <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

// >>> lfc_flash_timer.sv
`timescale 1ns/1ns
// ----------------------------------------
// flash time limit counter
// ----------------------------------------
module lfc_flash_timer import lfc_pkg::*; #(
    parameter int BASE_CYC = LFC_FTO_BASE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [3:0] sel,
    output logic expired
);
    logic [31:0] cnt_r;
    logic [31:0] limit;
    // 16 durations, 40 ms per code step
    assign limit = (32'(sel) + 32'h1) * 32'(BASE_CYC);
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !run) begin
            cnt_r <= 32'h0;
            expired <= 1'b0;
        end else if (cnt_r >= limit - 32'h1) begin
            expired <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule

// >>> lfc_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// - mode 11 selects flash, target is flash level bits 6:0
// - flash and torch current ramps up one code at a time to target, drops to a lower target at once
// - flash started by mode field clears mode on time-out
// - mode 10 selects torch, target is torch level bits 6:0
// - torch ramp step rate chosen by config bit 0
// - mode 01 selects IR, full eight-bit flash target, converter in pass
// - IR current follows strobe level; host owns pulse timing
// - IR current switches instantly, no ramp
// - IR time-out forces standby even with strobe high
// - start in pass; boost only when headroom drops below required
// - config bits 7:5 give droop threshold, 2.9 V plus 100 mV steps
// - input droop crossing halts the flash ramp during start-up
// - undervoltage, thermal shutdown, LED short or OVP shutdown sets its flag and clears the mode field; overcurrent only sets its flag
// - after a fault stay in standby until flag read clears flags
// - fault still present after read sets flag again, standby
// - each overvoltage trip blanks low-side switch until release level is reached
// - three overvoltage events in a row shut down and set bit 0
// - switching resumes once output falls below release level
// - at 125 C the flash target becomes the torch level
// - flags for time-out, heat, LED short, shutdown, fold, undervoltage
// - four-bit time-out field gives 16 durations, 40 to 640 ms
module lfc_ctrl import lfc_pkg::*; #(
    parameter int FTO_BASE_CYC = LFC_FTO_BASE_CYC,
    parameter int STEP_FAST_CYC = LFC_STEP_FAST_CYC,
    parameter int STEP_SLOW_CYC = LFC_STEP_SLOW_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic strobe,
    input wire logic headroom_low,
    input wire logic droop_trip,
    input wire logic ovp_trip,
    input wire logic ovp_release,
    input wire logic sw_cycle,
    input wire logic thermal_current_fold,
    input wire logic thermal_shutdown_trip,
    input wire logic uvlo_trip,
    input wire logic led_short,
    input wire logic ocp_trip,
    output logic [7:0] led_code,
    output logic boost_en,
    output logic lowside_en,
    output logic [2:0] input_droop_threshold
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] mode_r;
    logic [7:0] cfg_r;
    logic [7:0] flash_r;
    logic [7:0] torch_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] level_r;
    logic [1:0] ovp_cnt_r;
    logic ovp_latch_r;
    logic fault_lock_r;
    lfc_state_t state_r;
    logic [1:0] mode_sel;
    logic [7:0] target;
    logic step_tick;
    logic fto_exp;
    logic fault_now;
    logic ovp_shut;
    logic active;
    logic flags_read;

    assign mode_sel = mode_r[1:0];
    assign flags_read = reg_rd && (reg_addr == LFC_ADDR_FLAGS);
    assign active = (mode_sel != LFC_MODE_STBY) && !fault_lock_r;

    function automatic logic [7:0] pick_target(input logic [1:0] m, input logic hot,
                                               input logic [7:0] fl, input logic [7:0] tr);
        logic [7:0] t;
        t = 8'h00;
        if (m == LFC_MODE_FLASH) begin
            t = hot ? {1'b0, tr[6:0]} : {1'b0, fl[6:0]};
        end else if (m == LFC_MODE_TORCH) begin
            t = {1'b0, tr[6:0]};
        end else if (m == LFC_MODE_IR) begin
            t = fl;
        end
        return t;
    endfunction

    assign target = pick_target(mode_sel, thermal_current_fold, flash_r, torch_r);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    lfc_ramp_step #(
        .FAST_CYC(STEP_FAST_CYC),
        .SLOW_CYC(STEP_SLOW_CYC)
    ) u_step (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(state_r == LFC_ST_RAMP),
        .slow(mode_sel == LFC_MODE_TORCH && cfg_r[LFC_CFG_RAMP_BIT]),
        .tick(step_tick)
    );

    lfc_flash_timer #(
        .BASE_CYC(FTO_BASE_CYC)
    ) u_fto (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(active && (mode_sel == LFC_MODE_FLASH || mode_sel == LFC_MODE_IR)),
        .sel(cfg_r[LFC_CFG_FTO_LSB +: 4]),
        .expired(fto_exp)
    );

    // ----------------------------------------
    // faults
    // ----------------------------------------
    assign ovp_shut = sw_cycle && ovp_trip && (ovp_cnt_r == 2'(LFC_OVP_TRIPS - 1));
    assign fault_now = ovp_shut || thermal_shutdown_trip || uvlo_trip || led_short;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ovp_cnt_r <= 2'h0;
        end else if (sw_cycle) begin
            if (!ovp_trip) begin
                ovp_cnt_r <= 2'h0;
            end else if (ovp_cnt_r != 2'(LFC_OVP_TRIPS - 1)) begin
                ovp_cnt_r <= ovp_cnt_r + 2'h1;
            end else begin
                ovp_cnt_r <= 2'h0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ovp_latch_r <= 1'b0;
        end else if (ovp_trip) begin
            ovp_latch_r <= 1'b1;
        end else if (ovp_release) begin
            ovp_latch_r <= 1'b0;
        end
    end

    always_comb begin
        flags_nxt = flags_read ? 8'h00 : flags_r;
        if (ovp_shut) begin
            flags_nxt[LFC_FLAG_OVP] = 1'b1;
        end
        if (uvlo_trip) begin
            flags_nxt[LFC_FLAG_UVLO] = 1'b1;
        end
        if (thermal_current_fold && active && mode_sel == LFC_MODE_FLASH) begin
            flags_nxt[LFC_FLAG_TSB] = 1'b1;
        end
        if (thermal_shutdown_trip) begin
            flags_nxt[LFC_FLAG_TSD] = 1'b1;
        end
        if (ocp_trip) begin
            flags_nxt[LFC_FLAG_OCP] = 1'b1;
        end
        if (led_short) begin
            flags_nxt[LFC_FLAG_SHORT] = 1'b1;
        end
        if (droop_trip && active) begin
            flags_nxt[LFC_FLAG_DROOP] = 1'b1;
        end
        if (fto_exp && active) begin
            flags_nxt[LFC_FLAG_FTO] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flags_r <= 8'h00;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fault_lock_r <= 1'b0;
        end else if (fault_now) begin
            fault_lock_r <= 1'b1;
        end else if (flags_read) begin
            fault_lock_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // register port
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_r <= LFC_RST_MODE;
        end else if (fault_now) begin
            mode_r[1:0] <= LFC_MODE_STBY;
        end else if (fto_exp && active) begin
            mode_r[1:0] <= LFC_MODE_STBY;
        end else if (reg_wr && reg_addr == LFC_ADDR_MODE) begin
            mode_r <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_r <= LFC_RST_CFG;
            flash_r <= LFC_RST_FLASH;
            torch_r <= LFC_RST_TORCH;
        end else if (reg_wr) begin
            if (reg_addr == LFC_ADDR_CFG) begin
                cfg_r <= reg_wdata;
            end else if (reg_addr == LFC_ADDR_FLASH) begin
                flash_r <= reg_wdata;
            end else if (reg_addr == LFC_ADDR_TORCH) begin
                torch_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == LFC_ADDR_MODE) begin
                reg_rdata <= mode_r;
            end else if (reg_addr == LFC_ADDR_CFG) begin
                reg_rdata <= cfg_r;
            end else if (reg_addr == LFC_ADDR_FLASH) begin
                reg_rdata <= flash_r;
            end else if (reg_addr == LFC_ADDR_TORCH) begin
                reg_rdata <= torch_r;
            end else if (reg_addr == LFC_ADDR_FLAGS) begin
                reg_rdata <= flags_r;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // current sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= LFC_ST_IDLE;
            level_r <= 8'h00;
        end else if (fault_now || !active) begin
            state_r <= fault_now || fault_lock_r ? LFC_ST_LOCK : LFC_ST_IDLE;
            level_r <= 8'h00;
        end else if (mode_sel == LFC_MODE_IR) begin
            state_r <= LFC_ST_HOLD;
            level_r <= strobe ? target : 8'h00;
        end else begin
            case (state_r)
                LFC_ST_IDLE, LFC_ST_LOCK: begin
                    state_r <= LFC_ST_RAMP;
                end
                LFC_ST_RAMP: begin
                    if (level_r == target) begin
                        state_r <= LFC_ST_HOLD;
                    end else if (level_r > target) begin
                        level_r <= target;
                    end else if (step_tick && !(droop_trip && mode_sel == LFC_MODE_FLASH)) begin
                        level_r <= level_r + 8'h01;
                    end
                end
                default: begin
                    if (level_r != target) begin
                        state_r <= LFC_ST_RAMP;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // converter and outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            boost_en <= 1'b0;
            lowside_en <= 1'b0;
            led_code <= 8'h00;
            input_droop_threshold <= 3'h0;
        end else begin
            boost_en <= active && mode_sel != LFC_MODE_IR && headroom_low;
            lowside_en <= active && mode_sel != LFC_MODE_IR && headroom_low
                && !ovp_trip && !ovp_latch_r;
            led_code <= level_r;
            input_droop_threshold <= cfg_r[LFC_CFG_DROOP_LSB +: 3];
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_ir_pass_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mode_sel == LFC_MODE_IR |=> !boost_en) else $error("boost on in IR mode");
    chk_ramp_one_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_r == LFC_ST_RAMP && $past(state_r) == LFC_ST_RAMP && level_r > $past(level_r))
        |-> level_r == $past(level_r) + 8'h01) else $error("ramp skipped a code");
    chk_fault_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fault_now |=> mode_sel == LFC_MODE_STBY) else $error("fault left mode set");
    chk_lock_until_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fault_lock_r && !flags_read) |=> fault_lock_r) else $error("lock dropped without read");
    chk_ovp_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ovp_shut |=> flags_r[LFC_FLAG_OVP]) else $error("ovp flag missing");
    chk_ovp_blank: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ovp_trip |=> !lowside_en) else $error("low side on during ovp");
    chk_ir_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (active && mode_sel == LFC_MODE_IR && !strobe && !fault_now) |=> level_r == 8'h00)
        else $error("IR current on with strobe low");
    chk_fto_stby: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fto_exp && active) |=> mode_sel == LFC_MODE_STBY) else $error("time-out kept mode");
    chk_droop_seq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (droop_trip && mode_sel == LFC_MODE_FLASH && state_r == LFC_ST_RAMP && level_r < target)
        |=> level_r <= $past(level_r)) else $error("ramp moved under droop");
    chk_ir_full_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (active && mode_sel == LFC_MODE_IR && strobe && !fault_now) |=> level_r == $past(flash_r))
        else $error("IR level not full flash code");
    chk_fold_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (active && mode_sel == LFC_MODE_FLASH && thermal_current_fold && !fault_now && state_r == LFC_ST_RAMP)
        |=> level_r <= {1'b0, $past(torch_r[6:0])}) else $error("fold let flash level pass torch level");
    chk_pass_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !headroom_low |=> !boost_en) else $error("boost on with headroom met");
    chk_lock_dark: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fault_lock_r |=> level_r == 8'h00) else $error("current on while locked");
    chk_fto_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fto_exp && active) |=> flags_r[LFC_FLAG_FTO]) else $error("time-out flag missing");
    sequence seq_lock_read;
        fault_lock_r && flags_read && !fault_now;
    endsequence
    chk_read_unlock: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_lock_read |=> !fault_lock_r) else $error("flags read left lock set");
endmodule

// >>> lfc_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// host register master and strobe source
// ----------------------------------------
module lfc_host_model (
    input wire logic ref_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    output logic strobe
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        strobe = 1'b0;
    end
    // released address and data show the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask
    // a flags read clears them
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        v = reg_rdata;
    endtask
    // level strobe, pulse timing owned here
    task automatic set_strobe(input logic v);
        @(posedge ref_clk);
        strobe <= v;
    endtask
endmodule

// >>> test_led_flash_mode_fault_control.sv
`timescale 1ns/1ns
module test_led_flash_mode_fault_control import lfc_pkg::*;;
    localparam int BASE = 50;
    localparam int FAST = 4;
    localparam int SLOW = 8;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, strobe, boost_en, lowside_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, led_code, d;
    logic [2:0] input_droop_threshold;
    logic [2:0] flt = 3'h0;
    logic headroom_low = 1'b0, droop_trip = 1'b0, ovp_trip = 1'b0, ovp_release = 1'b1;
    logic sw_cycle = 1'b0, thermal_current_fold = 1'b0, ocp_trip = 1'b0;
    int err_total = 0, num_checks = 0, n, m;
    lfc_ctrl #(.FTO_BASE_CYC(BASE), .STEP_FAST_CYC(FAST), .STEP_SLOW_CYC(SLOW)) DUT (
        .ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .strobe,
        .headroom_low, .droop_trip, .ovp_trip, .ovp_release, .sw_cycle, .thermal_current_fold,
        .thermal_shutdown_trip(flt[1]), .uvlo_trip(flt[0]), .led_short(flt[2]), .ocp_trip,
        .led_code, .boost_en, .lowside_en, .input_droop_threshold
    );
    lfc_host_model HOST (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .strobe);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_win(input int v, input int lo, input int hi);
        num_checks++;
        if (v < lo || v > hi) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        HOST.rd(a, d);
        chk8(d, exp);
    endtask
    task automatic mode(input logic [1:0] md);
        HOST.wr(LFC_ADDR_MODE, {6'h00, md});
    endtask
    task automatic ramp_to(input logic [7:0] tgt, output int k);
        logic [7:0] prev;
        prev = led_code;
        k = 0;
        while (led_code !== tgt && k < 2000) begin
            tick(1);
            k++;
            if (led_code !== prev) begin
                chk8(led_code, prev + 8'h01);
                prev = led_code;
            end
        end
        chk8(led_code, tgt);
    endtask
    task automatic wait_zero(output int k);
        k = 0;
        while (led_code !== 8'h00 && k < 2000) begin
            tick(1);
            k++;
        end
    endtask
    task automatic sw_pulse();
        @(posedge ref_clk) sw_cycle <= 1'b1;
        @(posedge ref_clk) sw_cycle <= 1'b0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        chk8(led_code, 8'h00);
        chk8({6'h00, boost_en, lowside_en}, 8'h00);
        for (int a = 0; a < 7; a++) begin
            rchk(8'(a), 8'h00);
        end
        HOST.wr(LFC_ADDR_FLAGS, 8'hFF);
        rchk(LFC_ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_cfg();
        for (int i = 0; i < 8; i++) begin
            HOST.wr(LFC_ADDR_CFG, {3'(i), 5'h00});
            tick(2);
            chk8({5'h00, input_droop_threshold}, 8'(i));
            rchk(LFC_ADDR_CFG, {3'(i), 5'h00});
        end
    endtask
    task automatic t_torch();
        HOST.wr(LFC_ADDR_TORCH, 8'h86);
        for (int s = 0; s < 2; s++) begin
            HOST.wr(LFC_ADDR_CFG, 8'(s));
            mode(LFC_MODE_TORCH);
            ramp_to(8'h06, n);
            m = s ? SLOW : FAST;
            chk_win(n, 5 * m, 7 * m + 4);
            tick(3 * m);
            chk8(led_code, 8'h06);
            mode(LFC_MODE_STBY);
            wait_zero(n);
            chk8(led_code, 8'h00);
        end
    endtask
    task automatic t_flash();
        HOST.wr(LFC_ADDR_CFG, 8'h02);
        HOST.wr(LFC_ADDR_FLASH, 8'h83);
        mode(LFC_MODE_FLASH);
        ramp_to(8'h03, n);
        wait_zero(m);
        chk_win(n + m, 2 * BASE - 8, 2 * BASE + 8);
        rchk(LFC_ADDR_MODE, 8'h00);
        rchk(LFC_ADDR_FLAGS, 8'h80);
    endtask
    task automatic t_ir();
        HOST.wr(LFC_ADDR_CFG, 8'h00);
        HOST.wr(LFC_ADDR_FLASH, 8'hA5);
        mode(LFC_MODE_IR);
        tick(3);
        chk8(led_code, 8'h00);
        HOST.set_strobe(1'b1);
        tick(2);
        chk8(led_code, 8'hA5);
        chk8({7'h00, boost_en}, 8'h00);
        HOST.set_strobe(1'b0);
        tick(2);
        chk8(led_code, 8'h00);
        HOST.set_strobe(1'b1);
        tick(2);
        chk8(led_code, 8'hA5);
        wait_zero(n);
        chk_win(n, 1, 2 * BASE);
        rchk(LFC_ADDR_MODE, 8'h00);
        HOST.set_strobe(1'b0);
        rchk(LFC_ADDR_FLAGS, 8'h80);
    endtask
    task automatic t_droop();
        HOST.wr(LFC_ADDR_CFG, 8'h1E);
        HOST.wr(LFC_ADDR_FLASH, 8'h20);
        mode(LFC_MODE_FLASH);
        ramp_to(8'h05, n);
        @(posedge ref_clk) droop_trip <= 1'b1;
        tick(2);
        m = led_code;
        tick(10 * FAST);
        chk8(led_code, 8'(m));
        @(posedge ref_clk) droop_trip <= 1'b0;
        mode(LFC_MODE_STBY);
        wait_zero(n);
        rchk(LFC_ADDR_FLAGS, 8'h40);
    endtask
    task automatic t_fold();
        HOST.wr(LFC_ADDR_TORCH, 8'h03);
        HOST.wr(LFC_ADDR_FLASH, 8'h40);
        @(posedge ref_clk) thermal_current_fold <= 1'b1;
        mode(LFC_MODE_FLASH);
        ramp_to(8'h03, n);
        tick(10 * FAST);
        chk8(led_code, 8'h03);
        @(posedge ref_clk) thermal_current_fold <= 1'b0;
        mode(LFC_MODE_STBY);
        wait_zero(n);
        rchk(LFC_ADDR_FLAGS, 8'h04);
    endtask
    task automatic t_ovp();
        mode(LFC_MODE_TORCH);
        tick(20);
        chk8({7'h00, boost_en}, 8'h00);
        @(posedge ref_clk) headroom_low <= 1'b1;
        tick(3);
        chk8({7'h00, boost_en}, 8'h01);
        for (int k = 0; k < 6; k++) begin
            if (k == 5) begin
                rchk(LFC_ADDR_MODE, 8'h02);
            end
            @(posedge ref_clk) ovp_trip <= (k != 2);
            ovp_release <= (k == 2);
            sw_pulse();
            tick(2);
            chk8({7'h00, lowside_en}, {7'h00, k == 2});
        end
        rchk(LFC_ADDR_MODE, 8'h00);
        rchk(LFC_ADDR_FLAGS, 8'h01);
        @(posedge ref_clk) ovp_trip <= 1'b0;
        ovp_release <= 1'b1;
        headroom_low <= 1'b0;
    endtask
    task automatic t_fault();
        for (int f = 0; f < 3; f++) begin
            m = 1 << (f == 0 ? LFC_FLAG_UVLO : f == 1 ? LFC_FLAG_TSD : LFC_FLAG_SHORT);
            mode(LFC_MODE_TORCH);
            tick(10);
            @(posedge ref_clk) flt[f] <= 1'b1;
            tick(3);
            rchk(LFC_ADDR_MODE, 8'h00);
            rchk(LFC_ADDR_FLAGS, 8'(m));
            rchk(LFC_ADDR_FLAGS, 8'(m));
            @(posedge ref_clk) flt[f] <= 1'b0;
            mode(LFC_MODE_TORCH);
            tick(20);
            chk8(led_code, 8'h00);
            rchk(LFC_ADDR_FLAGS, 8'(m));
            rchk(LFC_ADDR_FLAGS, 8'h00);
        end
    endtask
    task automatic t_ocp();
        @(posedge ref_clk) ocp_trip <= 1'b1;
        tick(2);
        @(posedge ref_clk) ocp_trip <= 1'b0;
        rchk(LFC_ADDR_MODE, 8'h02);
        rchk(LFC_ADDR_FLAGS, 8'h10);
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        tick(1);
        t_regs();
        t_cfg();
        t_torch();
        t_flash();
        t_ir();
        t_droop();
        t_fold();
        t_ovp();
        t_fault();
        t_ocp();
        complete_run();
    end
    initial begin
        #300000;
        err_total++;
        complete_run();
    end
endmodule
